// >>> rtl/psrc_pkg.sv
// Package for the peripheral soft reset control block.
// Assumes a 32-bit classic Wishbone slave port and one system clock.
package psrc_pkg;
	localparam int          PSRC_AW            = 8;
	localparam int          PSRC_DW            = 32;
	localparam logic [7:0]  PSRC_OFS_TIMSER    = 8'h44;
	localparam logic [7:0]  PSRC_OFS_IOPORT    = 8'h48;
	localparam logic [31:0] PSRC_RST_TIMSER    = 32'h0000_0000;
	localparam logic [31:0] PSRC_RST_IOPORT    = 32'h0000_0000;
	localparam logic [31:0] PSRC_IMPL_TIMSER   = 32'h0307_0011;
	localparam logic [31:0] PSRC_IMPL_IOPORT   = 32'h0000_00ff;
	localparam int          PSRC_BIT_COMPARATOR_ONE_RESET     = 25;
	localparam int          PSRC_BIT_COMPARATOR_ZERO_RESET     = 24;
	localparam int          PSRC_BIT_TMR2      = 18;
	localparam int          PSRC_BIT_TMR1      = 17;
	localparam int          PSRC_BIT_TMR0      = 16;
	localparam int          PSRC_BIT_SSER      = 4;
	localparam int          PSRC_BIT_ASER      = 0;
	localparam int          PSRC_NPORTS        = 8;
	localparam logic [31:0] PSRC_UNMAPPED_DATA = 32'h0000_0000;
endpackage : psrc_pkg

// >>> rtl/psrc_mask_reg.sv
// One masked soft reset register.
// Assumes write strobe and lane enables come from the bus slave.
module psrc_mask_reg
	import psrc_pkg::*;
#(
	parameter logic [31:0] IMPL  = 32'hffff_ffff,
	parameter logic [31:0] RSTV  = 32'h0000_0000
) (
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        reset_i,
	// Write port
	input  wire logic        wr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] data_i,
	input  wire logic [31:0] cap_i,
	// Value
	output logic      [31:0] value_o
);
	typedef struct packed {
		logic [31:0] value;
	} psrc_mreg_s;
	psrc_mreg_s st;
	psrc_mreg_s next_st;
	logic [31:0] wmask;

	always_comb begin
		next_st = st;
		for (int i = 0; i < 4; i++) begin
			wmask[i*8 +: 8] = {8{sel_i[i]}};
		end
		wmask = wmask & cap_i & IMPL;
		if (wr_i) begin
			next_st.value = (st.value & ~wmask) | (data_i & wmask);
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st.value <= RSTV;
		end else begin
			st <= next_st;
		end
	end

	assign value_o = st.value;

	held_bits_a: assert property (@(posedge clock_i) disable iff (reset_i)
		!wr_i |=> (value_o == $past(value_o)))
		else $error("register changed without a write");
	reserved_zero_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(value_o & ~IMPL) == 32'h0000_0000)
		else $error("reserved bit set");
	cap_guard_a: assert property (@(posedge clock_i) disable iff (reset_i)
		1'b1 |=> ((value_o ^ $past(value_o)) & ~$past(cap_i)) == 32'h0000_0000)
		else $error("bit changed outside capability mask");
endmodule : psrc_mask_reg

// >>> rtl/psrc_reset_drive.sv
// Registered reset drivers, one per controlled unit.
// Assumes control bits come from the same clock domain.
module psrc_reset_drive #(
	parameter int N = 8
) (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         reset_i,
	// Control
	input  wire logic [N-1:0] ctrl_i,
	// Reset outputs
	output logic      [N-1:0] rst_o
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_drv
			typedef struct packed {
				logic r;
			} psrc_drv_s;
			psrc_drv_s st;
			psrc_drv_s next_st;
			always_comb begin
				next_st.r = ctrl_i[g];
			end
			always_ff @(posedge clock_i) begin
				if (reset_i) begin
					st.r <= 1'b0;
				end else begin
					st <= next_st;
				end
			end
			assign rst_o[g] = st.r;
		end
	endgenerate

	follow_ctrl_a: assert property (@(posedge clock_i) disable iff (reset_i)
		1'b1 |=> (rst_o == $past(ctrl_i)))
		else $error("reset output lags control by more than a cycle");
endmodule : psrc_reset_drive

// >>> rtl/psrc_top.sv
// Peripheral soft reset control: two masked registers on classic Wishbone.
// Assumes capability masks are static inputs from the same clock domain.
// Notes on behaviour
// - Writes to the timer/serial register change only bits enabled by mask two.
// - Writes to the io port register change only bits enabled by mask four.
// - Bits 25 and 24 drive the resets of comparators one and zero.
// - Bits 18, 17 and 16 drive the resets of counters two, one and zero.
// - Bit 4 drives the reset of the synchronous serial unit.
// - Bit 0 drives the reset of the asynchronous serial unit.
// - Io port register bits 7 to 0 drive resets of ports H to A.
// - Unassigned bits are read-only zero and software preserves them.
// - Both registers clear to zero on system reset.
//
// Our own choice: register access over Wishbone.
module psrc_top
	import psrc_pkg::*;
(
	// Clock and reset
	input  wire logic                         clock_i,
	input  wire logic                         reset_i,
	// Wishbone slave
	input  wire logic                         wb_cyc_i,
	input  wire logic                         wb_stb_i,
	input  wire logic                         wb_we_i,
	input  wire logic [psrc_pkg::PSRC_AW-1:0] wb_adr_i,
	input  wire logic [3:0]                   wb_sel_i,
	input  wire logic [psrc_pkg::PSRC_DW-1:0] wb_dat_i,
	output logic      [psrc_pkg::PSRC_DW-1:0] wb_dat_o,
	output logic                              wb_ack_o,
	// Capability masks
	input  wire logic [31:0]                  capability_mask_two_i,
	input  wire logic [31:0]                  capability_mask_four_i,
	// Peripheral resets
	output logic                              comparator_one_reset_o,
	output logic                              comparator_zero_reset_o,
	output logic                              gp_counter_two_reset_o,
	output logic                              gp_counter_one_reset_o,
	output logic                              gp_counter_zero_reset_o,
	output logic                              sync_serial_zero_reset_o,
	output logic                              async_serial_zero_reset_o,
	output logic      [psrc_pkg::PSRC_NPORTS-1:0] io_port_reset_o
);
	import psrc_pkg::*;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} psrc_bus_s;
	psrc_bus_s st;
	psrc_bus_s next_st;

	logic        req;
	logic        hit_ts;
	logic        hit_io;
	logic [31:0] ts_val;
	logic [31:0] io_val;
	logic [14:0] drv_rst;

	// One-cycle answer; ack low for a cycle between requests
	// Writes commit at the edge the master samples ack, so an aborted cycle writes nothing
	assign req    = wb_cyc_i & wb_stb_i & ~st.ack;
	assign hit_ts = wb_adr_i == PSRC_OFS_TIMSER;
	assign hit_io = wb_adr_i == PSRC_OFS_IOPORT;

	psrc_mask_reg #(
		.IMPL (PSRC_IMPL_TIMSER),
		.RSTV (PSRC_RST_TIMSER)
	) u_ts (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.wr_i    (st.ack & wb_cyc_i & wb_stb_i & wb_we_i & hit_ts),
		.sel_i   (wb_sel_i),
		.data_i  (wb_dat_i),
		.cap_i   (capability_mask_two_i),
		.value_o (ts_val)
	);

	psrc_mask_reg #(
		.IMPL (PSRC_IMPL_IOPORT),
		.RSTV (PSRC_RST_IOPORT)
	) u_io (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.wr_i    (st.ack & wb_cyc_i & wb_stb_i & wb_we_i & hit_io),
		.sel_i   (wb_sel_i),
		.data_i  (wb_dat_i),
		.cap_i   (capability_mask_four_i),
		.value_o (io_val)
	);

	always_comb begin
		next_st     = st;
		next_st.ack = req;
		if (req && !wb_we_i) begin
			if (hit_ts) begin
				next_st.dat = ts_val;
			end else if (hit_io) begin
				next_st.dat = io_val;
			end else begin
				next_st.dat = PSRC_UNMAPPED_DATA;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			st.ack <= 1'b0;
			st.dat <= 32'h0000_0000;
		end else begin
			st <= next_st;
		end
	end

	assign wb_ack_o = st.ack;
	assign wb_dat_o = st.dat;

	psrc_reset_drive #(
		.N (15)
	) u_drv (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.ctrl_i  ({ts_val[PSRC_BIT_COMPARATOR_ONE_RESET], ts_val[PSRC_BIT_COMPARATOR_ZERO_RESET],
		           ts_val[PSRC_BIT_TMR2], ts_val[PSRC_BIT_TMR1], ts_val[PSRC_BIT_TMR0],
		           ts_val[PSRC_BIT_SSER], ts_val[PSRC_BIT_ASER],
		           io_val[PSRC_NPORTS-1:0]}),
		.rst_o   (drv_rst)
	);

	// Flop outputs sit inside the driver module
	assign comparator_one_reset_o    = drv_rst[14];
	assign comparator_zero_reset_o   = drv_rst[13];
	assign gp_counter_two_reset_o    = drv_rst[12];
	assign gp_counter_one_reset_o    = drv_rst[11];
	assign gp_counter_zero_reset_o   = drv_rst[10];
	assign sync_serial_zero_reset_o  = drv_rst[9];
	assign async_serial_zero_reset_o = drv_rst[8];
	assign io_port_reset_o           = drv_rst[7:0];

	ack_one_cycle_a: assert property (@(posedge clock_i) disable iff (reset_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	ack_follows_req_a: assert property (@(posedge clock_i) disable iff (reset_i)
		(wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
		else $error("no ack one cycle after request");
	read_masked_a: assert property (@(posedge clock_i) disable iff (reset_i)
		wb_ack_o |-> (wb_dat_o & ~(PSRC_IMPL_TIMSER | PSRC_IMPL_IOPORT)) == 32'h0)
		else $error("reserved read data not zero");
	comp_reset_a: assert property (@(posedge clock_i) disable iff (reset_i)
		1'b1 |=> comparator_one_reset_o == $past(ts_val[PSRC_BIT_COMPARATOR_ONE_RESET]))
		else $error("comparator reset not following bit");
	uart_reset_a: assert property (@(posedge clock_i) disable iff (reset_i)
		1'b1 |=> async_serial_zero_reset_o == $past(ts_val[PSRC_BIT_ASER]))
		else $error("async serial reset not following bit");
	port_reset_a: assert property (@(posedge clock_i) disable iff (reset_i)
		1'b1 |=> io_port_reset_o == $past(io_val[7:0]))
		else $error("port reset not following bits");
	io_cap_a: assert property (@(posedge clock_i) disable iff (reset_i)
		1'b1 |=> ((io_val ^ $past(io_val)) & ~$past(capability_mask_four_i)) == 32'h0)
		else $error("io bit changed outside mask");
	reset_clear_a: assert property (@(posedge clock_i)
		reset_i |=> (ts_val == PSRC_RST_TIMSER && io_val == PSRC_RST_IOPORT))
		else $error("registers not cleared by reset");
	timer_ssi_a: assert property (@(posedge clock_i) disable iff (reset_i)
		1'b1 |=> (gp_counter_two_reset_o == $past(ts_val[PSRC_BIT_TMR2])
		       && sync_serial_zero_reset_o == $past(ts_val[PSRC_BIT_SSER])))
		else $error("counter or sync serial reset wrong");

	write_ts_c: cover property (@(posedge clock_i) req && wb_we_i && hit_ts);
	write_io_c: cover property (@(posedge clock_i) req && wb_we_i && hit_io);
	read_back_c: cover property (@(posedge clock_i) req && !wb_we_i && hit_ts);
	release_c: cover property (@(posedge clock_i) $fell(gp_counter_zero_reset_o));
endmodule : psrc_top

// >>> verif/psrc_periph_model.sv
// Far side: reset inputs of the controlled units, seven singles then eight ports.
// Assumes the resets are active-high levels in the system clock domain.
module psrc_periph_model (
	// Clock
	input  wire logic        clock_i,
	// Unit resets
	input  wire logic [14:0] unit_reset_i,
	// Units seen held in reset
	output logic      [14:0] held_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// A unit only sees its reset at its own clock edge
	always_ff @(posedge clock_i) begin
		held_o <= unit_reset_i;
	end
endmodule : psrc_periph_model

// >>> verif/tb_top.sv
// Bench for the peripheral soft reset control block.
// Assumes a classic Wishbone slave that acks one cycle after taking a request.
module tb_top;
	import psrc_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, m2 = '0, m4 = '0, rd;
	logic [6:0] single;
	logic [7:0] ports;
	logic [14:0] held;
	int err_count = 0, comparisons = 0, cycles = 0;
	always #25 clk = ~clk;
	psrc_top uut (.clock_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .capability_mask_two_i(m2), .capability_mask_four_i(m4),
		.comparator_one_reset_o(single[6]), .comparator_zero_reset_o(single[5]),
		.gp_counter_two_reset_o(single[4]), .gp_counter_one_reset_o(single[3]),
		.gp_counter_zero_reset_o(single[2]), .sync_serial_zero_reset_o(single[1]),
		.async_serial_zero_reset_o(single[0]), .io_port_reset_o(ports));
	psrc_periph_model peer (.clock_i(clk), .unit_reset_i({single, ports}), .held_o(held));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	always @(posedge clk) begin
		cycles++;
		if (cycles > 3000) begin
			err_count++;
			end_sim();
		end
	end
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Request held until ack is sampled high, then released for a cycle
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= s;
		do @(posedge clk); while (ack !== 1'b1);
		rd = rdat;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk);
	endtask : bus
	task automatic outs(logic [6:0] es, logic [7:0] ep);
		repeat (2) @(posedge clk);
		chk("single resets", {25'h0, es}, {25'h0, single});
		chk("port resets", {24'h0, ep}, {24'h0, ports});
		@(posedge clk);
		chk("held units", {17'h0, es, ep}, {17'h0, held});
	endtask : outs
	task automatic t_reset();
		bus(0, 8'h44, '0, 4'hf); chk("timser reset", 32'h0, rd);
		bus(0, 8'h48, '0, 4'hf); chk("ioport reset", 32'h0, rd);
		outs(7'h00, 8'h00);
		$display("test reset done");
	endtask : t_reset
	task automatic t_timser();
		m2 <= 32'h0100_0010;
		bus(1, 8'h44, 32'hffff_ffff, 4'hf);
		bus(0, 8'h44, '0, 4'hf); chk("timser masked", 32'h0100_0010, rd);
		outs(7'b0100010, 8'h00);
		m2 <= 32'hffff_ffff;
		bus(1, 8'h44, 32'hffff_ffff, 4'hf);
		bus(0, 8'h44, '0, 4'hf); chk("timser all", 32'h0307_0011, rd);
		outs(7'h7f, 8'h00);
		bus(1, 8'h44, 32'h0200_0001, 4'hf);
		outs(7'b1000001, 8'h00);
		bus(1, 8'h44, 32'h0, 4'hf);
		outs(7'h00, 8'h00);
		$display("test timser done");
	endtask : t_timser
	task automatic t_ioport();
		m4 <= 32'h0000_00f0;
		bus(1, 8'h48, 32'hffff_ffff, 4'hf);
		bus(0, 8'h48, '0, 4'hf); chk("ioport masked", 32'h0000_00f0, rd);
		m4 <= 32'hffff_ffff;
		bus(1, 8'h48, 32'h0000_005a, 4'h1);
		bus(1, 8'h48, 32'h0000_0000, 4'he);
		bus(0, 8'h48, '0, 4'hf); chk("ioport lanes", 32'h0000_005a, rd);
		outs(7'h00, 8'h5a);
		bus(1, 8'h4c, 32'hffff_ffff, 4'hf);
		bus(0, 8'h4c, '0, 4'hf); chk("unmapped", 32'h0, rd);
		$display("test ioport done");
	endtask : t_ioport
	task automatic t_rerun();
		m2 <= 32'hffff_ffff;
		m4 <= 32'hffff_ffff;
		bus(1, 8'h44, 32'hffff_ffff, 4'hf);
		bus(1, 8'h48, 32'hffff_ffff, 4'hf);
		rst <= 1;
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		bus(0, 8'h44, '0, 4'hf); chk("timser rerun", 32'h0, rd);
		bus(0, 8'h48, '0, 4'hf); chk("ioport rerun", 32'h0, rd);
		outs(7'h00, 8'h00);
		$display("test rerun done");
	endtask : t_rerun
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		t_reset();
		t_timser();
		t_ioport();
		t_rerun();
		end_sim();
	end
endmodule : tb_top
